// ### controller_fault_status_bank.v
/*
  Controller fault status bank: the controller fault word and the three
  system status words, read over the device register port.
  Assumes fault detect inputs are one-cycle or level indications from the
  control core, synchronous to clk, and that self-test and app-reset
  results come with a done strobe.
*/
`timescale 1ns/1ps
`include "fault_status_consts.vh"

module controller_fault_status_bank (
  input  wire                        clk,
  input  wire                        sys_rst,
  // register port
  input  wire                        regRd,
  input  wire                        regWr,
  input  wire [`ADDR_W-1:0]          regAddr,
  input  wire [`DATA_W-1:0]          regWrData,
  output wire [`DATA_W-1:0]          regRdData,
  output wire                        regRdValid,
  output wire                        regAddrErr,
  output wire                        regWrIgnored,
  // fault detections from the control core
  input  wire                        positionDetectFreqError,
  input  wire                        positionDetectFirstTimingError,
  input  wire                        positionDetectSecondTimingError,
  input  wire                        abnormalSpeedLock,
  input  wire                        syncLostLock,
  input  wire                        motorAbsentFault,
  input  wire                        cycleCurrentLimitFault,
  input  wire                        lockCurrentLimitFault,
  input  wire                        motorSupplyLowFault,
  input  wire                        motorSupplyHighFault,
  input  wire                        externalWatchdogExpired,
  input  wire                        faultClear,
  // self-test and application reset results
  input  wire                        selfTestEnabled,
  input  wire                        selfTestDone,
  input  wire                        selfTestPassed,
  input  wire                        appResetDone,
  input  wire                        appResetOk,
  // system status sources
  input  wire [`VOLT_W-1:0]          supplyVoltage,
  input  wire [`SPEED_CMD_W-1:0]     speedCommand,
  input  wire                        serialEntryDone,
  input  wire [`STATE_W-1:0]         controlState,
  input  wire                        selfTestFault,
  input  wire [`MOTOR_SPEED_W-1:0]   motorSpeed,
  input  wire [`BUS_CURR_W-1:0]      busCurrent,
  input  wire [`BATT_POW_W-1:0]      batteryPower,
  // status outputs
  output reg                         controllerFault_r,
  output reg                         motorLock_r,
  output wire                        newFault
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // place a single flag into a 32-bit word at a given position
  function [`DATA_W-1:0] placeBit;
    input         val;
    input integer pos;
    begin
      placeBit = {{(`DATA_W-1){1'b0}}, val} << pos;
    end
  endfunction

  // ----------------------------------------------------------------
  // sticky fault flags
  // ----------------------------------------------------------------
  wire [`NUM_FLAGS-1:0] detect;
  wire [`NUM_FLAGS-1:0] flags;

  assign detect[`FLG_POS_FREQ]     = positionDetectFreqError;
  assign detect[`FLG_POS_FIRST]    = positionDetectFirstTimingError;
  assign detect[`FLG_POS_SECOND]   = positionDetectSecondTimingError;
  assign detect[`FLG_ABNORMAL_SPEED_LOCK]    = abnormalSpeedLock;
  assign detect[`FLG_SYNC_LOST]    = syncLostLock;
  assign detect[`FLG_MOTOR_ABSENT] = motorAbsentFault;
  assign detect[`FLG_CYCLE_ILIM]   = cycleCurrentLimitFault;
  assign detect[`FLG_LOCK_ILIM]    = lockCurrentLimitFault;
  assign detect[`FLG_SUPPLY_LOW]   = motorSupplyLowFault;
  assign detect[`FLG_SUPPLY_HIGH]  = motorSupplyHighFault;
  assign detect[`FLG_WATCHDOG]     = externalWatchdogExpired;

  // the flags only clear from the core side; register writes never reach here
  fault_flag_bank u_flags (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .detect     (detect),
    .clearAll   (faultClear),
    .flags_r    (flags),
    .newFault_r (newFault)
  );

  // ----------------------------------------------------------------
  // summaries
  // ----------------------------------------------------------------
  wire anyLock;
  wire anyFault;

  // lock-current limit counts as a lock detection as well
  assign anyLock  = flags[`FLG_ABNORMAL_SPEED_LOCK] | flags[`FLG_SYNC_LOST] |
                    flags[`FLG_MOTOR_ABSENT] | flags[`FLG_LOCK_ILIM];
  // self-test and app-reset bits are results, not faults, so stay out of it
  assign anyFault = (|flags) | anyLock;

  always @(posedge clk) begin
    if (sys_rst) begin
      controllerFault_r <= 1'b0;
      motorLock_r       <= 1'b0;
    end else begin
      controllerFault_r <= anyFault;
      motorLock_r       <= anyLock;
    end
  end

  // ----------------------------------------------------------------
  // self-test and application reset results
  // ----------------------------------------------------------------
  reg selfTestEn_r;
  reg selfTestPass_r;
  reg appResetOk_r;

  always @(posedge clk) begin
    if (sys_rst) begin
      selfTestEn_r   <= 1'b0;
      selfTestPass_r <= 1'b0;
      appResetOk_r   <= 1'b0;
    end else begin
      selfTestEn_r <= selfTestEnabled;
      // result is held until the next run reports, so a read between runs
      // still sees the last outcome
      if (selfTestDone) begin
        selfTestPass_r <= selfTestPassed;
      end
      if (appResetDone) begin
        appResetOk_r <= appResetOk;
      end
    end
  end

  // ----------------------------------------------------------------
  // controller fault word
  // ----------------------------------------------------------------
  wire [`DATA_W-1:0] ctrlFaultWord;

  // unlisted positions are simply never filled, so they read zero
  assign ctrlFaultWord =
      placeBit(anyFault,                   `BIT_ANY_FAULT)      |
      placeBit(flags[`FLG_POS_FREQ],       `BIT_POS_FREQ)       |
      placeBit(flags[`FLG_POS_FIRST],      `BIT_POS_FIRST)      |
      placeBit(flags[`FLG_POS_SECOND],     `BIT_POS_SECOND)     |
      placeBit(flags[`FLG_ABNORMAL_SPEED_LOCK],      `BIT_ABNORMAL_SPEED_LOCK)      |
      placeBit(flags[`FLG_SYNC_LOST],      `BIT_SYNC_LOST)      |
      placeBit(flags[`FLG_MOTOR_ABSENT],   `BIT_MOTOR_ABSENT)   |
      placeBit(anyLock,                    `BIT_ANY_LOCK)       |
      placeBit(flags[`FLG_CYCLE_ILIM],     `BIT_CYCLE_ILIM)     |
      placeBit(flags[`FLG_LOCK_ILIM],      `BIT_LOCK_ILIM)      |
      placeBit(flags[`FLG_SUPPLY_LOW],     `BIT_SUPPLY_LOW)     |
      placeBit(flags[`FLG_SUPPLY_HIGH],    `BIT_SUPPLY_HIGH)    |
      placeBit(flags[`FLG_WATCHDOG],       `BIT_WATCHDOG)       |
      placeBit(selfTestEn_r,               `BIT_SELF_TEST_EN)   |
      placeBit(selfTestPass_r,             `BIT_SELF_TEST_PASS) |
      placeBit(appResetOk_r,               `BIT_APP_RESET_OK);

  // ----------------------------------------------------------------
  // system status words
  // ----------------------------------------------------------------
  // registered so a read returns a value sampled in one cycle, not a
  // mixture of fields moving under the read
  reg [`DATA_W-1:0] sysWordOne_r;
  reg [`DATA_W-1:0] sysWordTwo_r;
  reg [`DATA_W-1:0] sysWordThree_r;

  always @(posedge clk) begin
    if (sys_rst) begin
      sysWordOne_r   <= `RST_SYS_WORD;
      sysWordTwo_r   <= `RST_SYS_WORD;
      sysWordThree_r <= `RST_SYS_WORD;
    end else begin
      sysWordOne_r   <= {supplyVoltage, speedCommand, serialEntryDone};
      sysWordTwo_r   <= {controlState, 10'h000, selfTestFault, 1'b0, motorSpeed};
      sysWordThree_r <= {busCurrent, batteryPower};
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  // write data is accepted on the port but has nowhere to go
  status_read_port u_port (
    .clk            (clk),
    .sys_rst        (sys_rst),
    .regRd          (regRd),
    .regWr          (regWr),
    .regAddr        (regAddr),
    .ctrlFaultWord  (ctrlFaultWord),
    .sysWordOne     (sysWordOne_r),
    .sysWordTwo     (sysWordTwo_r),
    .sysWordThree   (sysWordThree_r),
    .regRdData_r    (regRdData),
    .regRdValid_r   (regRdValid),
    .regAddrErr_r   (regAddrErr),
    .regWrIgnored_r (regWrIgnored)
  );

endmodule // controller_fault_status_bank

// ### controller_fault_status_bank_tb.sv
/*
  Self-checking bench for the controller fault status bank.
  Assumes the design and its constants header are compiled before it.
*/
`timescale 1ns/1ps
`include "fault_status_consts.vh"
`define CHK(g, e, m) begin n_tests++; if ((g) !== (e)) begin failures++; $display("wrong value at %0t ns: %s", $time, m); end end
module controller_fault_status_bank_tb;
  logic        clk = 1'h0, sys_rst = 1'h1, regRd = 1'h0, regWr = 1'h0, faultClear = 1'h0;
  logic        selfTestEnabled = 1'h0, selfTestDone = 1'h0, selfTestPassed = 1'h0;
  logic        appResetDone = 1'h0, appResetOk = 1'h0, serialEntryDone = 1'h0, selfTestFault = 1'h0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0, regRdData;
  logic [10:0] det = 11'h000;
  logic [15:0] supplyVoltage = 16'h0, motorSpeed = 16'h0, busCurrent = 16'h0, batteryPower = 16'h0;
  logic [14:0] speedCommand = 15'h0;
  logic [3:0]  controlState = 4'h0;
  logic        regRdValid, regAddrErr, regWrIgnored, controllerFault_r, motorLock_r, newFault;
  int          failures = 0;
  int          n_tests = 0;
  always #12.5 clk = ~clk;
  controller_fault_status_bank controller_fault_status_bank_i (
    .clk(clk), .sys_rst(sys_rst), .regRd(regRd), .regWr(regWr), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .regRdValid(regRdValid), .regAddrErr(regAddrErr), .regWrIgnored(regWrIgnored),
    .positionDetectFreqError(det[0]), .positionDetectFirstTimingError(det[1]),
    .positionDetectSecondTimingError(det[2]), .abnormalSpeedLock(det[3]), .syncLostLock(det[4]),
    .motorAbsentFault(det[5]), .cycleCurrentLimitFault(det[6]), .lockCurrentLimitFault(det[7]),
    .motorSupplyLowFault(det[8]), .motorSupplyHighFault(det[9]), .externalWatchdogExpired(det[10]),
    .faultClear(faultClear), .selfTestEnabled(selfTestEnabled), .selfTestDone(selfTestDone),
    .selfTestPassed(selfTestPassed), .appResetDone(appResetDone), .appResetOk(appResetOk),
    .supplyVoltage(supplyVoltage), .speedCommand(speedCommand), .serialEntryDone(serialEntryDone),
    .controlState(controlState), .selfTestFault(selfTestFault), .motorSpeed(motorSpeed),
    .busCurrent(busCurrent), .batteryPower(batteryPower), .controllerFault_r(controllerFault_r),
    .motorLock_r(motorLock_r), .newFault(newFault));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // expected fault word from the flag set and the three low result bits
  function automatic logic [31:0] exp_word(input logic [10:0] f, input logic [2:0] low);
    return {|f, 1'h0, f[0], f[1], f[2], 3'h0, f[3], f[4], f[5], f[3] | f[4] | f[5] | f[7],
            f[6], f[7], f[8], f[9], f[10], 12'h000, low};
  endfunction
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk) regRd <= 1'h1;
    regAddr <= a;
    @(posedge clk) regRd <= 1'h0;
    #1;
    `CHK(regRdValid, 1'h1, "read not answered")
    d = regRdData;
  endtask
  task automatic wr(input logic [7:0] a, input logic unmapped);
    @(posedge clk) regWr <= 1'h1;
    regAddr <= a;
    regWrData <= 32'hffffffff;
    @(posedge clk) regWr <= 1'h0;
    #1;
    `CHK({regWrIgnored, regAddrErr}, {1'h1, unmapped}, "write response")
  endtask
  task automatic pulse(input logic [10:0] m, input logic clr);
    @(posedge clk) det <= m;
    faultClear <= clr;
    @(posedge clk) det <= 11'h000;
    faultClear <= 1'h0;
    #1;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    logic [31:0] d;
    rd(`OFS_CTRL_FAULT, d);
    `CHK(d, 32'h00000000, "fault word after reset")
    $display("test reset values done");
  endtask
  task automatic t_each_flag();
    logic [31:0] d;
    for (int i = 0; i < 11; i++) begin
      pulse(11'h001 << i, 1'h0);
      `CHK(newFault, 1'h1, "new fault pulse")
      rd(`OFS_CTRL_FAULT, d);
      `CHK(d, exp_word(11'h001 << i, 3'h0), "single flag word")
      `CHK(controllerFault_r, 1'h1, "fault summary out")
      `CHK(motorLock_r, (i == 3 || i == 4 || i == 5 || i == 7) ? 1'h1 : 1'h0, "lock summary out")
      pulse(11'h000, 1'h1);
    end
    rd(`OFS_CTRL_FAULT, d);
    `CHK(d, 32'h00000000, "word after clear")
    $display("test each flag done");
  endtask
  task automatic t_results();
    logic [31:0] d;
    logic [2:0]  pat [4] = '{3'h5, 3'h2, 3'h5, 3'h0};
    logic [2:0]  want [4] = '{3'h5, 3'h2, 3'h6, 3'h0};
    // third step moves the levels with no done strobe: bits 1 and 0 must hold
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) selfTestEnabled <= pat[k][2];
      selfTestPassed <= pat[k][1];
      appResetOk <= pat[k][0];
      selfTestDone <= (k != 2);
      appResetDone <= (k != 2);
      @(posedge clk) selfTestDone <= 1'h0;
      appResetDone <= 1'h0;
      @(posedge clk);
      rd(`OFS_CTRL_FAULT, d);
      `CHK(d, {29'h0, want[k]}, "self-test and app reset bits")
    end
    $display("test result bits done");
  endtask
  task automatic t_writes();
    logic [31:0] d;
    pulse(11'h400, 1'h0);
    wr(`OFS_CTRL_FAULT, 1'h0);
    wr(8'hee, 1'h1);
    rd(`OFS_CTRL_FAULT, d);
    `CHK(d, exp_word(11'h400, 3'h0), "write changed the fault word")
    pulse(11'h001, 1'h1);
    rd(`OFS_CTRL_FAULT, d);
    `CHK(d, exp_word(11'h001, 3'h0), "write changed word or clear beat set")
    pulse(11'h000, 1'h1);
    $display("test writes done");
  endtask
  task automatic t_unmapped();
    logic [31:0] d;
    logic [7:0]  addrs [4] = '{8'he3, 8'he6, 8'h00, 8'hff};
    foreach (addrs[j]) begin
      rd(addrs[j], d);
      `CHK({regAddrErr, d}, {1'h1, 32'h0}, "unmapped read")
    end
    $display("test unmapped reads done");
  endtask
  task automatic t_sys_words();
    logic [31:0] d;
    @(posedge clk) supplyVoltage <= 16'h1234;
    speedCommand <= 15'h2a5a;
    serialEntryDone <= 1'h1;
    controlState <= 4'h9;
    selfTestFault <= 1'h1;
    motorSpeed <= 16'hbeef;
    busCurrent <= 16'h0f0f;
    batteryPower <= 16'ha5c3;
    rd(`OFS_SYS_WORD_ONE, d);
    `CHK({regAddrErr, d}, {1'h0, 32'h123454b5}, "system word one")
    rd(`OFS_SYS_WORD_TWO, d);
    `CHK({regAddrErr, d}, {1'h0, 32'h9002beef}, "system word two")
    rd(`OFS_SYS_WORD_THREE, d);
    `CHK({regAddrErr, d}, {1'h0, 32'h0f0fa5c3}, "system word three")
    $display("test system words done");
  endtask
  task automatic t_mid_reset();
    logic [31:0] d;
    pulse(11'h088, 1'h0);
    @(posedge clk) sys_rst <= 1'h1;
    @(posedge clk) sys_rst <= 1'h0;
    rd(`OFS_CTRL_FAULT, d);
    `CHK({d, controllerFault_r, motorLock_r}, 34'h0, "flags survive reset")
    $display("test mid-run reset done");
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog: the whole sequence needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'h0;
    t_reset_values();
    t_each_flag();
    t_results();
    t_writes();
    t_unmapped();
    t_sys_words();
    t_mid_reset();
    report_and_stop();
  end
endmodule // controller_fault_status_bank_tb
bind controller_fault_status_bank fault_status_bank_props props_i (
  .clk(clk), .sys_rst(sys_rst), .regRd(regRd), .regWr(regWr), .regAddr(regAddr), .regRdData(regRdData),
  .regRdValid(regRdValid), .regAddrErr(regAddrErr), .regWrIgnored(regWrIgnored),
  .positionDetectFreqError(positionDetectFreqError), .positionDetectFirstTimingError(positionDetectFirstTimingError),
  .positionDetectSecondTimingError(positionDetectSecondTimingError), .abnormalSpeedLock(abnormalSpeedLock),
  .syncLostLock(syncLostLock), .motorAbsentFault(motorAbsentFault), .cycleCurrentLimitFault(cycleCurrentLimitFault),
  .lockCurrentLimitFault(lockCurrentLimitFault), .motorSupplyLowFault(motorSupplyLowFault),
  .motorSupplyHighFault(motorSupplyHighFault), .externalWatchdogExpired(externalWatchdogExpired),
  .selfTestEnabled(selfTestEnabled), .controllerFault_r(controllerFault_r), .motorLock_r(motorLock_r));

// ### fault_flag_bank.v
/*
  Sticky fault flags: each flag sets on its detect input and holds until
  an internal clear. Assumes synchronous detect and clear inputs.
*/
`timescale 1ns/1ps
`include "fault_status_consts.vh"

module fault_flag_bank (
  input  wire                    clk,
  input  wire                    sys_rst,
  input  wire [`NUM_FLAGS-1:0]   detect,
  input  wire                    clearAll,
  output reg  [`NUM_FLAGS-1:0]   flags_r,
  output reg                     newFault_r
);

  wire [`NUM_FLAGS-1:0] flags_nxt;
  wire [`NUM_FLAGS-1:0] rising;

  // a detect in the clearing cycle survives: set wins over clear
  assign flags_nxt = (clearAll ? {`NUM_FLAGS{1'b0}} : flags_r) | detect;
  assign rising    = detect & ~flags_r;

  always @(posedge clk) begin
    if (sys_rst) begin
      flags_r    <= {`NUM_FLAGS{1'b0}};
      newFault_r <= 1'b0;
    end else begin
      flags_r    <= flags_nxt;
      newFault_r <= |rising;
    end
  end

endmodule // fault_flag_bank

// ### fault_status_bank_props.sv
/*
  Checker for the controller fault status bank, watching its top ports only.
  Assumes it is bound to the top module from the bench top file.
*/
`timescale 1ns/1ps
`include "fault_status_consts.vh"
module fault_status_bank_props (
  input logic                clk,
  input logic                sys_rst,
  input logic                regRd,
  input logic                regWr,
  input logic [`ADDR_W-1:0]  regAddr,
  input logic [`DATA_W-1:0]  regRdData,
  input logic                regRdValid,
  input logic                regAddrErr,
  input logic                regWrIgnored,
  input logic                positionDetectFreqError,
  input logic                positionDetectFirstTimingError,
  input logic                positionDetectSecondTimingError,
  input logic                abnormalSpeedLock,
  input logic                syncLostLock,
  input logic                motorAbsentFault,
  input logic                cycleCurrentLimitFault,
  input logic                lockCurrentLimitFault,
  input logic                motorSupplyLowFault,
  input logic                motorSupplyHighFault,
  input logic                externalWatchdogExpired,
  input logic                selfTestEnabled,
  input logic                controllerFault_r,
  input logic                motorLock_r
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  wire lockDet = abnormalSpeedLock | syncLostLock | motorAbsentFault | lockCurrentLimitFault;
  wire anyDet  = lockDet | positionDetectFreqError | positionDetectFirstTimingError
               | positionDetectSecondTimingError | cycleCurrentLimitFault | motorSupplyLowFault
               | motorSupplyHighFault | externalWatchdogExpired;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  rst_clear_a: assert property (disable iff (1'h0) sys_rst |=> regRdData == 32'h0 && !controllerFault_r)
    else $error("status not cleared by reset");
  rd_answer_a: assert property (regRd |=> regRdValid)
    else $error("read not answered in one cycle");
  fault_sum_a: assert property (anyDet |-> ##2 controllerFault_r)
    else $error("fault summary output missing");
  lock_sum_a: assert property (lockDet |-> ##2 motorLock_r)
    else $error("lock summary output missing");
  sum_bit_a: assert property (regRdValid && $past(regAddr) == `OFS_CTRL_FAULT
    |-> regRdData[31] == |{regRdData[29:27], regRdData[23:15]}) else $error("bit 31 not the fault OR");
  lock_bit_a: assert property (regRdValid && $past(regAddr) == `OFS_CTRL_FAULT
    |-> regRdData[20] == (regRdData[23] | regRdData[22] | regRdData[21] | regRdData[18]))
    else $error("bit 20 not the lock OR");
  resv_zero_a: assert property (regRdValid && $past(regAddr) == `OFS_CTRL_FAULT
    |-> regRdData[30] == 1'h0 && regRdData[26:24] == 3'h0 && regRdData[14:3] == 12'h0)
    else $error("reserved bits not zero");
  stest_mirror_a: assert property (regRdValid && $past(regAddr) == `OFS_CTRL_FAULT && !$past(sys_rst, 2)
    |-> regRdData[2] == $past(selfTestEnabled, 2)) else $error("self-test enable not mirrored");
  wr_ignore_a: assert property (regWr && !regRd |=> regWrIgnored && $stable(regRdData))
    else $error("write not ignored");
  unmapped_rd_a: assert property (regRd && !(regAddr inside {8'he2, 8'he4, 8'hea, 8'hec})
    |=> regAddrErr && regRdData == 32'h0) else $error("unmapped read not zero");
endmodule // fault_status_bank_props

// ### fault_status_consts.vh
/*
  Constants of the controller fault status bank: register offsets, field
  positions, reset values and port widths.
  Assumes it is included by its bare name from each design file.
*/
// What this block does
// - controller fault word sits at E2h and reads 00000000h after reset.
// - bit 31 is the OR of every controller fault flag in the word.
// - bit 29 flags a position-detection frequency fault, else zero.
// - bit 28 flags a position-detection first-timing fault, else zero.
// - bit 27 flags a position-detection second-timing fault, else zero.
// - bit 23 flags an abnormal-speed motor lock, else zero.
// - bit 22 flags loss of commutation sync as a lock, else zero.
// - bit 21 flags that no motor is connected, else zero.
// - bit 20 is set whenever any motor lock detection triggers.
// - bit 19 flags a cycle-by-cycle current limit fault, else zero.
// - bit 18 flags the lock-detection current limit fault, else zero.
// - bit 17 flags motor supply undervoltage, else zero.
// - bit 16 flags motor supply overvoltage, else zero.
// - bit 15 flags external watchdog timeout, else zero.
// - bit 2 mirrors the nonvolatile self-test enable setting.
// - bit 1 reads 1 when self-test passed, 0 on failure.
// - bit 0 reads 1 when application reset succeeded, 0 on failure.
`ifndef FAULT_STATUS_CONSTS_VH
`define FAULT_STATUS_CONSTS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_W              8
`define DATA_W              32
`define OFS_CTRL_FAULT      8'he2
`define OFS_SYS_WORD_ONE    8'he4
`define OFS_SYS_WORD_TWO    8'hea
`define OFS_SYS_WORD_THREE  8'hec

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_CTRL_FAULT      32'h00000000
`define RST_SYS_WORD        32'h00000000

// ----------------------------------------------------------------
// controller fault word fields
// ----------------------------------------------------------------
`define BIT_ANY_FAULT       31
`define BIT_POS_FREQ        29
`define BIT_POS_FIRST       28
`define BIT_POS_SECOND      27
`define BIT_ABNORMAL_SPEED_LOCK       23
`define BIT_SYNC_LOST       22
`define BIT_MOTOR_ABSENT    21
`define BIT_ANY_LOCK        20
`define BIT_CYCLE_ILIM      19
`define BIT_LOCK_ILIM       18
`define BIT_SUPPLY_LOW      17
`define BIT_SUPPLY_HIGH     16
`define BIT_WATCHDOG        15
`define BIT_SELF_TEST_EN    2
`define BIT_SELF_TEST_PASS  1
`define BIT_APP_RESET_OK    0

// sticky flag vector: index order inside the flag bank
`define NUM_FLAGS           11
`define FLG_POS_FREQ        0
`define FLG_POS_FIRST       1
`define FLG_POS_SECOND      2
`define FLG_ABNORMAL_SPEED_LOCK       3
`define FLG_SYNC_LOST       4
`define FLG_MOTOR_ABSENT    5
`define FLG_CYCLE_ILIM      6
`define FLG_LOCK_ILIM       7
`define FLG_SUPPLY_LOW      8
`define FLG_SUPPLY_HIGH     9
`define FLG_WATCHDOG        10

// ----------------------------------------------------------------
// system status word field widths
// ----------------------------------------------------------------
`define VOLT_W              16
`define SPEED_CMD_W         15
`define STATE_W             4
`define MOTOR_SPEED_W       16
`define BUS_CURR_W          16
`define BATT_POW_W          16

`endif

// ### status_read_port.v
/*
  Register read port of the status bank: decodes the offset, returns the
  addressed word one cycle after the strobe, zero for unmapped offsets.
  Assumes single-cycle read and write strobes from the register port.
*/
`timescale 1ns/1ps
`include "fault_status_consts.vh"

module status_read_port (
  input  wire                 clk,
  input  wire                 sys_rst,
  input  wire                 regRd,
  input  wire                 regWr,
  input  wire [`ADDR_W-1:0]   regAddr,
  input  wire [`DATA_W-1:0]   ctrlFaultWord,
  input  wire [`DATA_W-1:0]   sysWordOne,
  input  wire [`DATA_W-1:0]   sysWordTwo,
  input  wire [`DATA_W-1:0]   sysWordThree,
  output reg  [`DATA_W-1:0]   regRdData_r,
  output reg                  regRdValid_r,
  output reg                  regAddrErr_r,
  output reg                  regWrIgnored_r
);

  reg [`DATA_W-1:0] rdData_nxt;
  reg               hit;

  always @* begin
    rdData_nxt = {`DATA_W{1'b0}};
    hit        = 1'b1;
    case (regAddr)
      `OFS_CTRL_FAULT:     rdData_nxt = ctrlFaultWord;
      `OFS_SYS_WORD_ONE:   rdData_nxt = sysWordOne;
      `OFS_SYS_WORD_TWO:   rdData_nxt = sysWordTwo;
      `OFS_SYS_WORD_THREE: rdData_nxt = sysWordThree;
      default:             hit        = 1'b0;
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      regRdData_r    <= {`DATA_W{1'b0}};
      regRdValid_r   <= 1'b0;
      regAddrErr_r   <= 1'b0;
      regWrIgnored_r <= 1'b0;
    end else begin
      regRdValid_r   <= regRd;
      regAddrErr_r   <= (regRd | regWr) & ~hit;
      // every word is read-only, so a write raises this pulse, plus the address error at an unmapped offset
      regWrIgnored_r <= regWr;
      if (regRd) begin
        regRdData_r <= rdData_nxt;
      end
    end
  end

endmodule // status_read_port
